// ==== verilog/iowdt_pkg.sv ====
// Package for the I/O port watchdog timer: port address, control byte layout,
// timebase and reset pulse constants.
// Assumes a 100 MHz core clock.
package iowdt_pkg;

  // ---------------------------------------------------------------
  // Port decode
  // ---------------------------------------------------------------
  localparam logic [15:0] IOWDT_PORT_ADDR = 16'h0214;
  localparam int IOWDT_ADDR_W = 16;

  // ---------------------------------------------------------------
  // Control byte fields
  // ---------------------------------------------------------------
  localparam int IOWDT_ENABLE_BIT = 7;
  localparam int IOWDT_ACTION_SELECT_BIT = 6;
  localparam int IOWDT_PERIOD_FIELD_MSB = 5;
  localparam int IOWDT_PERIOD_W = IOWDT_PERIOD_FIELD_MSB + 1;
  localparam logic [7:0] IOWDT_CTRL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int IOWDT_CLK_MHZ = 100;
  localparam int IOWDT_TICK_S = 1;
  localparam int IOWDT_TICK_CYCLES = IOWDT_TICK_S * IOWDT_CLK_MHZ * 1000000;
  localparam int IOWDT_RST_PULSE_NS = 1000;
  localparam int IOWDT_RST_PULSE_CYCLES = (IOWDT_RST_PULSE_NS * IOWDT_CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    IOWDT_IDLE,
    IOWDT_COUNT,
    IOWDT_EXPIRED
  } iowdt_state_t;

endpackage : iowdt_pkg

// ==== verilog/iowdt_tick_gen.sv ====
// One-cycle enable pulse divider for the watchdog timebase.
// Assumes a single free-running core clock; clear restarts the phase.
`timescale 1ns/1ps
module iowdt_tick_gen #(
  parameter int DIV = 100000000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Control
  input wire logic clear,
  // Tick
  output logic tick
);

  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn || clear) begin
      cnt_reg <= '0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn || clear) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_reg == LAST);
    end
  end

endmodule : iowdt_tick_gen

// ==== verilog/iowdt_top.sv ====
// I/O port watchdog timer: one write-only control byte on the host I/O bus.
// Assumes the host I/O write strobe is synchronous to core_clk, one cycle per write.
//
// Summary of operation
// RULE1 - Decode control byte writes at port 214H
// RULE2 - Watchdog disabled after any system reset
// RULE3 - Trigger write clears elapsed counter, restarts
// RULE4 - Expiry gives reset pulse or IRQ9
// RULE5 - D7 enable, D6 action, D5..D0 period
// RULE6 - Period field counts whole seconds
// RULE7 - Value 88H raises IRQ9 after eight seconds
// RULE8 - Host rewrites value within each period
// RULE9 - New period adopted on any write
// RULE10 - One-second tick; fixed-length reset pulse
`timescale 1ns/1ps
module iowdt_top
  import iowdt_pkg::*;
#(
  parameter int TICK_CYCLES = IOWDT_TICK_CYCLES,
  parameter int RST_PULSE_CYCLES = IOWDT_RST_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Host I/O write port
  input wire logic [IOWDT_ADDR_W-1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  // Expiry actions
  output logic sys_reset_pulse,
  output logic irq9,
  // Status
  output logic wdt_running
);

  localparam int PW = $clog2(RST_PULSE_CYCLES + 1);
  localparam logic [PW-1:0] PULSE_LAST = PW'(RST_PULSE_CYCLES);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic hit;
  logic tick;
  logic enable;
  logic action_reset;
  logic [IOWDT_PERIOD_W-1:0] period;
  logic [IOWDT_PERIOD_W-1:0] elapsed_reg;
  logic [PW-1:0] pulse_cnt_reg;
  iowdt_state_t state_reg;

  assign hit = io_wr && (io_addr == IOWDT_PORT_ADDR); // RULE1
  assign enable = ctrl_reg[IOWDT_ENABLE_BIT]; // RULE5
  assign action_reset = ctrl_reg[IOWDT_ACTION_SELECT_BIT]; // RULE5
  assign period = ctrl_reg[IOWDT_PERIOD_FIELD_MSB:0]; // RULE5

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_reg <= IOWDT_CTRL_RESET; // RULE2
    end else if (hit) begin
      ctrl_reg <= io_wdata; // RULE9
    end
  end

  // ---------------------------------------------------------------
  // One-second timebase
  // ---------------------------------------------------------------
  iowdt_tick_gen #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .resetn(resetn),
    .clear(hit), // RULE3
    .tick(tick) // RULE10
  );

  // ---------------------------------------------------------------
  // Elapsed seconds and state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn || hit) begin
      elapsed_reg <= '0; // RULE3
    end else if (state_reg == IOWDT_COUNT && tick) begin
      elapsed_reg <= elapsed_reg + IOWDT_PERIOD_W'(1); // RULE6
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= IOWDT_IDLE; // RULE2
    end else if (hit) begin
      state_reg <= io_wdata[IOWDT_ENABLE_BIT] ? IOWDT_COUNT : IOWDT_IDLE; // RULE3
    end else begin
      unique case (state_reg)
        IOWDT_IDLE: begin
          state_reg <= IOWDT_IDLE;
        end
        IOWDT_COUNT: begin
          if (enable && tick && (elapsed_reg + IOWDT_PERIOD_W'(1) >= period)) begin
            state_reg <= IOWDT_EXPIRED; // RULE4
          end
        end
        IOWDT_EXPIRED: begin
          state_reg <= IOWDT_EXPIRED;
        end
        default: begin
          state_reg <= IOWDT_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Expiry actions
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pulse_cnt_reg <= '0;
    end else if (state_reg == IOWDT_COUNT && !hit && enable && action_reset && tick
                 && (elapsed_reg + IOWDT_PERIOD_W'(1) >= period)) begin
      pulse_cnt_reg <= PULSE_LAST; // RULE4
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_reg <= pulse_cnt_reg - PW'(1); // RULE10
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sys_reset_pulse <= 1'b0;
    end else begin
      sys_reset_pulse <= (pulse_cnt_reg != '0); // RULE4
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq9 <= 1'b0;
    end else begin
      irq9 <= (state_reg == IOWDT_EXPIRED) && !action_reset; // RULE7
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wdt_running <= 1'b0;
    end else begin
      wdt_running <= (state_reg == IOWDT_COUNT);
    end
  end

endmodule : iowdt_top

// ==== sim/iowdt_top_asserts.sv ====
// Port checker for the watchdog top.
// Bound to iowdt_top at the foot.
`timescale 1ns/1ps
module iowdt_top_asserts
  import iowdt_pkg::*;
#(
  parameter int TICK_CYCLES = 20,
  parameter int RST_PULSE_CYCLES = 4
) (
  // Clock, reset, bus
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [IOWDT_ADDR_W-1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  // Outputs
  input wire logic sys_reset_pulse,
  input wire logic irq9,
  input wire logic wdt_running
);
  logic w;
  int plen;
  assign w = io_wr && io_addr == IOWDT_PORT_ADDR;
  always_ff @(posedge core_clk) plen <= sys_reset_pulse ? plen + 1 : 0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // No expiry action may start in the eight cycles beginning two cycles after a trigger
  sequence s_quiet;
    (!irq9 && !$rose(sys_reset_pulse)) [*8];
  endsequence
  AST_RUN: assert property (w && io_wdata[7] |-> ##2 wdt_running) else $error("no start");
  AST_OFF: assert property (w && !io_wdata[7] |-> ##2 !wdt_running && !irq9) else $error("no stop");
  AST_DEC: assert property (io_wr && !w && !$past(w) && !wdt_running |-> ##2 !wdt_running) else $error("dec");
  AST_RST: assert property (disable iff (1'b0) !resetn |=> !wdt_running && !irq9 && !sys_reset_pulse)
    else $error("reset");
  AST_HOLD: assert property (irq9 && !w && !$past(w) |=> irq9) else $error("irq drop");
  AST_EXCL: assert property (irq9 |-> !wdt_running && !sys_reset_pulse) else $error("excl");
  AST_PULSE: assert property ($fell(sys_reset_pulse) && $past(resetn) |-> plen == RST_PULSE_CYCLES)
    else $error("len");
  AST_TRIG: assert property (w && io_wdata[7] |-> ##2 s_quiet) else $error("early");
  AST_CAUSE: assert property (($rose(irq9) || $rose(sys_reset_pulse)) |-> $past(wdt_running))
    else $error("expiry while not counting");
endmodule : iowdt_top_asserts

bind iowdt_top iowdt_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .RST_PULSE_CYCLES(RST_PULSE_CYCLES)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
  .sys_reset_pulse(sys_reset_pulse), .irq9(irq9), .wdt_running(wdt_running));

// ==== sim/iowdt_top_test.sv ====
// Self-checking bench for the watchdog top.
// Drives the write port at the falling edge.
`timescale 1ns/1ps
module iowdt_top_test;
  import iowdt_pkg::*;
  localparam int T = 20;
  logic core_clk = 0, resetn = 0, io_wr = 0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00;
  logic sys_reset_pulse, irq9, wdt_running;
  logic [7:0] tab [5] = '{8'h88, 8'hC8, 8'hCF, 8'h80, 8'h00};
  int fail_count = 0, n_compared = 0, cyc = 0, seed = 32'h44d9b982, n;
  iowdt_top #(.TICK_CYCLES(T), .RST_PULSE_CYCLES(4)) dut (.core_clk(core_clk), .resetn(resetn),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .sys_reset_pulse(sys_reset_pulse),
    .irq9(irq9), .wdt_running(wdt_running));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1;
    @(negedge core_clk);
    io_wr = 0;
  endtask : wr
  function automatic int exp_cyc(input logic [7:0] d);
    return ((d[5:0] == 0) ? 1 : d[5:0]) * T;
  endfunction : exp_cyc
  // Waits for expiry, checks delay, action and pulse length
  task automatic expire(input logic [7:0] d);
    n = 0;
    while (!(irq9 || sys_reset_pulse) && n < 1400) begin
      @(negedge core_clk);
      n++;
    end
    check(n >= exp_cyc(d) - 2 && n <= exp_cyc(d) + 3, 1);
    check(irq9, !d[6]);
    n = 0;
    while (sys_reset_pulse) begin
      @(negedge core_clk);
      n++;
    end
    check(n, d[6] ? 4 : 0);
  endtask : expire
  initial begin
    repeat (3) @(negedge core_clk);
    resetn = 1;
    check({sys_reset_pulse, irq9, wdt_running}, 0);
    repeat (20) begin
      n = $random(seed);
      wr(n[15:0] == 16'h0214 ? 16'h0215 : n[15:0], 8'h80 | n[23:16]);
      repeat (2) @(negedge core_clk);
      check(wdt_running, 0);
    end
    tab[4] = 8'h80 | 8'($random(seed));
    foreach (tab[i]) begin
      wr(16'h0214, tab[i]);
      expire(tab[i]);
      wr(16'h0214, 8'h00);
    end
    repeat (5) begin
      wr(16'h0214, 8'h83);
      repeat (50) @(negedge core_clk);
      check(irq9, 0);
    end
    wr(16'h0214, 8'h82);
    expire(8'h82);
    // Disable in mid-count: no action may follow
    wr(16'h0214, 8'hC2);
    repeat (10) @(negedge core_clk);
    wr(16'h0214, 8'h40);
    repeat (60) begin
      @(negedge core_clk);
      check({sys_reset_pulse, irq9, wdt_running}, 0);
    end
    wr(16'h0214, 8'hC5);
    repeat (10) @(negedge core_clk);
    resetn = 0;
    @(negedge core_clk);
    resetn = 1;
    repeat (40) @(negedge core_clk);
    check({sys_reset_pulse, irq9, wdt_running}, 0);
    tally_and_finish();
  end
endmodule : iowdt_top_test
